// ===== verilog/sev_status_top.sv
`timescale 1ns/10ps
module sev_status_top
  import sev_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // instrument command port
  input wire sev_cmd_t cmd,
  output sev_rsp_t rsp,
  // condition sources
  input wire logic calibrating,
  input wire logic [15:0] oper_cond,
  input wire logic [15:0] ques_cond,
  // standard event sources, message available
  input wire sev_std_src_t std_src,
  input wire logic ops_pending,
  input wire logic msg_available,
  // status byte
  output logic [7:0] status_byte
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sev_strobe_t strobe;
  logic [15:0] oper_cond_in;
  logic [15:0] oper_cond_q;
  logic [15:0] oper_event;
  logic [15:0] oper_enable;
  logic oper_summary_raw;
  logic [15:0] ques_cond_q;
  logic [15:0] ques_event;
  logic [15:0] ques_enable;
  logic ques_summary_raw;
  logic [7:0] std_event;
  logic [7:0] std_enable;
  logic [7:0] std_set;
  logic std_clear;
  logic opc_armed;
  logic opc_hit;
  logic power_seen;
  logic [7:0] next_status_byte;
  logic [15:0] next_rsp_data;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  sev_cmd_decode u_decode (
    .cmd(cmd),
    .strobe(strobe)
  );

  // ---------------------------------------------------------------
  // operation and questionable groups
  // ---------------------------------------------------------------
  // calibration owns bit 0 so a falling filter can flag completion
  always_comb begin
    oper_cond_in = oper_cond;
    oper_cond_in[SEV_OPER_CALIBRATING] = calibrating;
  end

  sev_status_group u_oper (
    .clock(clock),
    .arst_n(arst_n),
    .cond(oper_cond_in),
    .ctl(strobe.oper),
    .wdata(cmd.data),
    .clear_ev(strobe.clear_all),
    .preset(strobe.preset),
    .cond_q(oper_cond_q),
    .event_bits(oper_event),
    .enable_bits(oper_enable),
    .summary(oper_summary_raw)
  );

  sev_status_group u_ques (
    .clock(clock),
    .arst_n(arst_n),
    .cond(ques_cond),
    .ctl(strobe.ques),
    .wdata(cmd.data),
    .clear_ev(strobe.clear_all),
    .preset(strobe.preset),
    .cond_q(ques_cond_q),
    .event_bits(ques_event),
    .enable_bits(ques_enable),
    .summary(ques_summary_raw)
  );

  // ---------------------------------------------------------------
  // power-on and operation-complete tracking
  // ---------------------------------------------------------------
  // first clocked cycle after reset release counts as power applied
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_seen <= 1'b0;
    end else begin
      power_seen <= 1'b1;
    end
  end

  // opc waits until nothing is pending; clear-status drops the wait
  assign opc_hit = opc_armed & ~ops_pending;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      opc_armed <= 1'b0;
    end else if (strobe.clear_all) begin
      opc_armed <= 1'b0;
    end else if (strobe.opc) begin
      opc_armed <= 1'b1;
    end else if (opc_hit) begin
      opc_armed <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // standard event register
  // ---------------------------------------------------------------
  always_comb begin
    std_set = SEV_STD_RESET;
    std_set[SEV_STD_OPC] = opc_hit;
    std_set[SEV_STD_QUERY_ERR] = std_src.query_err;
    std_set[SEV_STD_DEV_ERR] = std_src.dev_err;
    std_set[SEV_STD_EXEC_ERR] = std_src.exec_err;
    std_set[SEV_STD_CMD_ERR] = std_src.cmd_err;
    std_set[SEV_STD_POWER_ON] = ~power_seen;
  end

  assign std_clear = strobe.rd_std | strobe.clear_all | strobe.preset;

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      std_event <= SEV_STD_RESET;
    end else begin
      std_event <= ((std_clear ? SEV_STD_RESET : std_event) | std_set)
                   & SEV_STD_USED_MASK;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      std_enable <= SEV_STD_RESET;
    end else if (strobe.preset) begin
      std_enable <= SEV_STD_RESET;
    end else if (strobe.wr_std_en) begin
      std_enable <= cmd.data[7:0];
    end
  end

  // ---------------------------------------------------------------
  // status byte, one cycle behind any event or enable change
  // ---------------------------------------------------------------
  always_comb begin
    next_status_byte = 8'h00;
    next_status_byte[SEV_STB_QUES] = ques_summary_raw;
    next_status_byte[SEV_STB_MAV] = msg_available;
    next_status_byte[SEV_STB_STD] = |(std_event & std_enable);
    next_status_byte[SEV_STB_OPER] = oper_summary_raw;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= next_status_byte;
    end
  end

  // ---------------------------------------------------------------
  // query answers; value returned is the one before the clear
  // ---------------------------------------------------------------
  always_comb begin
    next_rsp_data = 16'h0000;
    if (strobe.oper.rd_event) begin
      next_rsp_data = oper_event;
    end else if (strobe.ques.rd_event) begin
      next_rsp_data = ques_event;
    end else if (strobe.rd_std) begin
      next_rsp_data = {8'h00, std_event};
    end else if (strobe.rd_oper_cond) begin
      next_rsp_data = oper_cond_q;
    end else if (strobe.rd_ques_cond) begin
      next_rsp_data = ques_cond_q;
    end else if (strobe.rd_stb) begin
      next_rsp_data = {8'h00, status_byte};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= strobe.oper.rd_event | strobe.ques.rd_event
                   | strobe.rd_std | strobe.rd_oper_cond
                   | strobe.rd_ques_cond | strobe.rd_stb;
      rsp.data <= next_rsp_data;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_unused_zero;
    @(posedge clock) disable iff (!arst_n)
      !std_event[SEV_STD_REQ_CTRL] && !std_event[SEV_STD_USER_REQ];
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused standard event bit is set");

  property p_power_on;
    @(posedge clock) disable iff (!arst_n)
      !power_seen |=> std_event[SEV_STD_POWER_ON] ##1 power_seen;
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("power-on bit not set after reset");

  property p_opc_done;
    @(posedge clock) disable iff (!arst_n)
      (opc_armed && !ops_pending && !strobe.clear_all)
        |=> std_event[SEV_STD_OPC] && !opc_armed;
  endproperty
  a_opc_done: assert property (p_opc_done)
    else $error("operation complete not reported");

  property p_opc_waits;
    @(posedge clock) disable iff (!arst_n)
      (opc_armed && ops_pending) |=> opc_armed || $past(strobe.clear_all);
  endproperty
  a_opc_waits: assert property (p_opc_waits)
    else $error("operation complete dropped while work pending");

  property p_query_err;
    @(posedge clock) disable iff (!arst_n)
      std_src.query_err |=> std_event[SEV_STD_QUERY_ERR];
  endproperty
  a_query_err: assert property (p_query_err)
    else $error("query error not recorded");

  property p_cmd_err;
    @(posedge clock) disable iff (!arst_n)
      std_src.cmd_err |=> std_event[SEV_STD_CMD_ERR];
  endproperty
  a_cmd_err: assert property (p_cmd_err)
    else $error("command error not recorded");

  property p_std_summary;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> status_byte[SEV_STB_STD]
               == $past(|(std_event & std_enable));
  endproperty
  a_std_summary: assert property (p_std_summary)
    else $error("standard event summary wrong");

  property p_oper_summary;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> status_byte[SEV_STB_OPER]
               == $past(|(oper_event & oper_enable));
  endproperty
  a_oper_summary: assert property (p_oper_summary)
    else $error("operation summary wrong");

  property p_ques_summary;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> status_byte[SEV_STB_QUES]
               == $past(|(ques_event & ques_enable));
  endproperty
  a_ques_summary: assert property (p_ques_summary)
    else $error("questionable summary wrong");

  property p_mav;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> status_byte[SEV_STB_MAV] == $past(msg_available);
  endproperty
  a_mav: assert property (p_mav)
    else $error("message available bit wrong");

endmodule : sev_status_top

// ===== verilog/sev_pkg.sv
package sev_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int SEV_GRP_W = 16;
  localparam int SEV_STD_W = 8;

  // ---------------------------------------------------------------
  // standard event bit positions
  // ---------------------------------------------------------------
  localparam int SEV_STD_OPC = 0;
  localparam int SEV_STD_REQ_CTRL = 1;
  localparam int SEV_STD_QUERY_ERR = 2;
  localparam int SEV_STD_DEV_ERR = 3;
  localparam int SEV_STD_EXEC_ERR = 4;
  localparam int SEV_STD_CMD_ERR = 5;
  localparam int SEV_STD_USER_REQ = 6;
  localparam int SEV_STD_POWER_ON = 7;

  // ---------------------------------------------------------------
  // status byte bit positions
  // ---------------------------------------------------------------
  localparam int SEV_STB_QUES = 3;
  localparam int SEV_STB_MAV = 4;
  localparam int SEV_STB_STD = 5;
  localparam int SEV_STB_OPER = 7;

  // operation condition bit driven by calibration
  localparam int SEV_OPER_CALIBRATING = 0;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [15:0] SEV_GRP_MASK = 16'h7fff;
  localparam logic [15:0] SEV_RISE_FILTER_RESET = 16'h7fff;
  localparam logic [15:0] SEV_FALL_FILTER_RESET = 16'h0000;
  localparam logic [15:0] SEV_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] SEV_EVENT_RESET = 16'h0000;
  localparam logic [7:0] SEV_STD_RESET = 8'h00;
  localparam logic [7:0] SEV_STD_USED_MASK = 8'hbd;

  // ---------------------------------------------------------------
  // command set
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SEV_OP_NOP,
    SEV_OP_WR_OPER_RISE,
    SEV_OP_WR_OPER_FALL,
    SEV_OP_WR_OPER_EN,
    SEV_OP_WR_QUES_RISE,
    SEV_OP_WR_QUES_FALL,
    SEV_OP_WR_QUES_EN,
    SEV_OP_WR_STD_EN,
    SEV_OP_RD_OPER_EV,
    SEV_OP_RD_QUES_EV,
    SEV_OP_RD_STD_EV,
    SEV_OP_RD_OPER_COND,
    SEV_OP_RD_QUES_COND,
    SEV_OP_RD_STB,
    SEV_OP_PRESET,
    SEV_OP_CLS,
    SEV_OP_RST,
    SEV_OP_OPC
  } sev_op_t;

  typedef struct packed {
    logic valid;
    sev_op_t op;
    logic [15:0] data;
  } sev_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sev_rsp_t;

  // standard event sources, one-cycle pulses
  typedef struct packed {
    logic query_err;
    logic dev_err;
    logic exec_err;
    logic cmd_err;
  } sev_std_src_t;

  typedef struct packed {
    logic wr_rise;
    logic wr_fall;
    logic wr_en;
    logic rd_event;
  } sev_grp_ctl_t;

  typedef struct packed {
    sev_grp_ctl_t oper;
    sev_grp_ctl_t ques;
    logic wr_std_en;
    logic rd_std;
    logic rd_oper_cond;
    logic rd_ques_cond;
    logic rd_stb;
    logic preset;
    logic clear_all;
    logic opc;
  } sev_strobe_t;

endpackage : sev_pkg

// ===== verilog/sev_cmd_decode.sv
`timescale 1ns/10ps
module sev_cmd_decode
  import sev_pkg::*;
(
  // command in
  input wire sev_cmd_t cmd,
  // decoded strobes
  output sev_strobe_t strobe
);

  // ---------------------------------------------------------------
  // one strobe per command, each filter register its own command
  // ---------------------------------------------------------------
  always_comb begin
    strobe = '0;
    if (cmd.valid) begin
      case (cmd.op)
        SEV_OP_WR_OPER_RISE: strobe.oper.wr_rise = 1'b1;
        SEV_OP_WR_OPER_FALL: strobe.oper.wr_fall = 1'b1;
        SEV_OP_WR_OPER_EN: strobe.oper.wr_en = 1'b1;
        SEV_OP_WR_QUES_RISE: strobe.ques.wr_rise = 1'b1;
        SEV_OP_WR_QUES_FALL: strobe.ques.wr_fall = 1'b1;
        SEV_OP_WR_QUES_EN: strobe.ques.wr_en = 1'b1;
        SEV_OP_WR_STD_EN: strobe.wr_std_en = 1'b1;
        SEV_OP_RD_OPER_EV: strobe.oper.rd_event = 1'b1;
        SEV_OP_RD_QUES_EV: strobe.ques.rd_event = 1'b1;
        SEV_OP_RD_STD_EV: strobe.rd_std = 1'b1;
        SEV_OP_RD_OPER_COND: strobe.rd_oper_cond = 1'b1;
        SEV_OP_RD_QUES_COND: strobe.rd_ques_cond = 1'b1;
        SEV_OP_RD_STB: strobe.rd_stb = 1'b1;
        SEV_OP_PRESET: strobe.preset = 1'b1;
        SEV_OP_CLS: strobe.clear_all = 1'b1;
        SEV_OP_RST: strobe.clear_all = 1'b1;
        SEV_OP_OPC: strobe.opc = 1'b1;
        default: strobe = '0;
      endcase
    end
  end

endmodule : sev_cmd_decode

// ===== verilog/sev_status_group.sv
`timescale 1ns/10ps
module sev_status_group
  import sev_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // condition and control
  input wire logic [15:0] cond,
  input wire sev_grp_ctl_t ctl,
  input wire logic [15:0] wdata,
  input wire logic clear_ev,
  input wire logic preset,
  // state
  output logic [15:0] cond_q,
  output logic [15:0] event_bits,
  output logic [15:0] enable_bits,
  output logic summary
);

  logic [15:0] cond_d;
  logic [15:0] rising_edge_filter;
  logic [15:0] falling_edge_filter;
  logic [15:0] rise_hit;
  logic [15:0] fall_hit;
  logic clear;

  // ---------------------------------------------------------------
  // condition sampling, previous value kept for edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cond_q <= '0;
      cond_d <= '0;
    end else begin
      cond_q <= cond & SEV_GRP_MASK;
      cond_d <= cond_q;
    end
  end

  // ---------------------------------------------------------------
  // transition filters, written separately
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rising_edge_filter <= SEV_RISE_FILTER_RESET;
      falling_edge_filter <= SEV_FALL_FILTER_RESET;
    end else if (preset) begin
      rising_edge_filter <= SEV_RISE_FILTER_RESET;
      falling_edge_filter <= SEV_FALL_FILTER_RESET;
    end else begin
      if (ctl.wr_rise) rising_edge_filter <= wdata & SEV_GRP_MASK;
      if (ctl.wr_fall) falling_edge_filter <= wdata & SEV_GRP_MASK;
    end
  end

  // truth table: a rise needs its rising bit, a fall its falling bit
  assign rise_hit = cond_q & ~cond_d & rising_edge_filter;
  assign fall_hit = ~cond_q & cond_d & falling_edge_filter;
  assign clear = ctl.rd_event | clear_ev | preset;

  // ---------------------------------------------------------------
  // sticky events; a hit in the clearing cycle survives the clear
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      event_bits <= SEV_EVENT_RESET;
    end else begin
      event_bits <= (clear ? SEV_EVENT_RESET : event_bits)
                    | rise_hit | fall_hit;
    end
  end

  // ---------------------------------------------------------------
  // enable register, cleared by preset
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enable_bits <= SEV_ENABLE_RESET;
    end else if (preset) begin
      enable_bits <= SEV_ENABLE_RESET;
    end else if (ctl.wr_en) begin
      enable_bits <= wdata & SEV_GRP_MASK;
    end
  end

  // left combinational so the status byte flop adds the only lag
  assign summary = |(event_bits & enable_bits);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_hit_sets_event;
    @(posedge clock) disable iff (!arst_n)
      |(rise_hit | fall_hit) |=>
        ((event_bits & $past(rise_hit | fall_hit))
         == $past(rise_hit | fall_hit));
  endproperty
  a_hit_sets_event: assert property (p_hit_sets_event)
    else $error("qualified transition did not set its event bit");

  property p_no_spurious_event;
    @(posedge clock) disable iff (!arst_n)
      1'b1 |=> ((event_bits & ~$past(event_bits)
                 & ~$past(rise_hit | fall_hit)) == 16'h0000);
  endproperty
  a_no_spurious_event: assert property (p_no_spurious_event)
    else $error("event bit set without a filtered transition");

  property p_clear_only_by_cmd;
    @(posedge clock) disable iff (!arst_n)
      !clear |=> ((~event_bits & $past(event_bits)) == 16'h0000);
  endproperty
  a_clear_only_by_cmd: assert property (p_clear_only_by_cmd)
    else $error("event bit cleared without a clearing command");

  property p_preset_defaults;
    @(posedge clock) disable iff (!arst_n)
      preset |=> (rising_edge_filter == SEV_RISE_FILTER_RESET)
                 && (falling_edge_filter == SEV_FALL_FILTER_RESET)
                 && (enable_bits == SEV_ENABLE_RESET);
  endproperty
  a_preset_defaults: assert property (p_preset_defaults)
    else $error("preset did not restore filter defaults");

endmodule : sev_status_group

// ===== verification/sev_host_model.sv
`timescale 1ns/10ps
module sev_host_model
  import sev_pkg::*;
(
  // clock
  input wire logic clock,
  // command port
  output sev_cmd_t cmd,
  input wire sev_rsp_t rsp
);
  sev_cmd_t cmd_q = '0;
  logic got_rsp = 1'b0;
  logic [15:0] last_rsp = 16'h0000;

  assign cmd = cmd_q;

  // one command held over its taking edge, then the answer is looked for
  // idle data is inverted so a stale word never passes for a fresh one
  // the answer stands only for the cycle after the taking edge, so it
  // is looked at inside that cycle, before the next edge drops it
  task automatic send(input sev_op_t op, input logic [15:0] data);
    got_rsp = 1'b0;
    @(posedge clock);
    cmd_q <= '{valid: 1'b1, op: op, data: data};
    @(posedge clock);
    cmd_q <= '{valid: 1'b0, op: SEV_OP_NOP, data: ~data};
    for (int i = 0; i < 2; i++) begin
      #1;
      if (rsp.valid === 1'b1 && got_rsp === 1'b0) begin
        got_rsp = 1'b1;
        last_rsp = rsp.data;
      end
      @(posedge clock);
    end
  endtask : send
endmodule : sev_host_model

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import sev_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic calibrating = 1'b0;
  logic [15:0] oper_cond = 16'h0000;
  logic [15:0] ques_cond = 16'h0000;
  sev_std_src_t std_src = '0;
  logic ops_pending = 1'b0;
  logic msg_available = 1'b0;
  sev_cmd_t cmd;
  sev_rsp_t rsp;
  logic [7:0] status_byte;
  int fails = 0;
  int cmp_count = 0;
  logic [15:0] lfsr = 16'h0052;
  logic [15:0] p;
  logic [15:0] n;
  logic [15:0] x;
  logic [15:0] e;

  // 50 ns period
  always #25 clock = ~clock;

  sev_status_top sev_status_top_inst (
    .clock(clock), .arst_n(arst_n), .cmd(cmd), .rsp(rsp),
    .calibrating(calibrating), .oper_cond(oper_cond),
    .ques_cond(ques_cond), .std_src(std_src), .ops_pending(ops_pending),
    .msg_available(msg_available), .status_byte(status_byte)
  );

  sev_host_model sev_host_model_inst (
    .clock(clock), .cmd(cmd), .rsp(rsp)
  );

  // fibonacci lfsr, taps 16 14 13 11
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // events recorded by one condition change through both filters
  function automatic logic [15:0] exp_ev(input logic [15:0] a, b, pt, nt);
    return ((~a & b & pt) | (a & ~b & nt)) & SEV_GRP_MASK;
  endfunction : exp_ev

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_rsp(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : check_rsp

  task automatic check_stb(input logic [7:0] exp);
    cmp_count++;
    if (status_byte !== exp) begin
      fails++;
      $display("CHECK FAILED status_byte exp %h got %h", exp, status_byte);
    end
  endtask : check_stb

  task automatic issue(input sev_op_t op, input logic [15:0] d);
    sev_host_model_inst.send(op, d);
  endtask : issue

  // a missing answer is a hang cut short
  task automatic query(input sev_op_t op, input logic [15:0] exp,
      input string what);
    issue(op, 16'h0000);
    if (sev_host_model_inst.got_rsp !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %s exp answer got none", what);
      report_and_stop();
    end
    check_rsp(what, exp, sev_host_model_inst.last_rsp);
  endtask : query

  // three edges: sample, event, summary
  task automatic set_cond(input logic [15:0] o, q);
    @(posedge clock);
    oper_cond <= o;
    ques_cond <= q;
    repeat (3) @(posedge clock);
    #1;
  endtask : set_cond

  task automatic pulse_src(input logic [3:0] b);
    @(posedge clock);
    std_src <= sev_std_src_t'(b);
    @(posedge clock);
    std_src <= '0;
    repeat (2) @(posedge clock);
    #1;
  endtask : pulse_src

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check_stb(8'h00);
    query(SEV_OP_RD_STD_EV, 16'h0080, "std");
    query(SEV_OP_RD_STD_EV, 16'h0000, "std");
    // power-on filters: rises recorded, falls ignored, events sticky
    set_cond(16'h0000, 16'hffff);
    set_cond(16'h0000, 16'h0000);
    query(SEV_OP_RD_QUES_EV, 16'h7fff, "ques");
    // random filters, each written by its own command
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      p = lfsr;
      lfsr = lfsr_next(lfsr);
      n = lfsr;
      lfsr = lfsr_next(lfsr);
      x = lfsr;
      e = exp_ev(16'h0000, x, p, n) | exp_ev(x, 16'h0000, p, n);
      issue(SEV_OP_WR_QUES_RISE, p);
      issue(SEV_OP_WR_QUES_FALL, n);
      issue(SEV_OP_WR_OPER_RISE, p);
      issue(SEV_OP_WR_OPER_FALL, n);
      set_cond(x, x);
      set_cond(16'h0000, 16'h0000);
      query(SEV_OP_RD_QUES_EV, e, "ques");
      query(SEV_OP_RD_OPER_EV, e & 16'hfffe, "oper");
    end
    // calibration end flagged through the falling filter
    issue(SEV_OP_WR_OPER_RISE, 16'h7ffe);
    issue(SEV_OP_WR_OPER_FALL, 16'h0001);
    issue(SEV_OP_WR_OPER_EN, 16'h0001);
    @(posedge clock) calibrating <= 1'b1;
    repeat (3) @(posedge clock);
    query(SEV_OP_RD_OPER_COND, 16'h0001, "cond");
    query(SEV_OP_RD_OPER_EV, 16'h0000, "oper");
    @(posedge clock) calibrating <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check_stb(8'h80);
    query(SEV_OP_RD_OPER_EV, 16'h0001, "oper");
    repeat (2) @(posedge clock);
    #1;
    check_stb(8'h00);
    // each error source; enable 52 leaves device error unreported
    issue(SEV_OP_WR_STD_EN, 16'h0034);
    for (int i = 0; i < 4; i++) begin
      pulse_src(4'h1 << i);
      check_stb(i == 2 ? 8'h00 : 8'h20);
      query(SEV_OP_RD_STD_EV, 16'h0020 >> i, "std");
    end
    // completion waits for pending work
    @(posedge clock) ops_pending <= 1'b1;
    issue(SEV_OP_OPC, 16'h0000);
    repeat (4) @(posedge clock);
    query(SEV_OP_RD_STD_EV, 16'h0000, "std");
    @(posedge clock) ops_pending <= 1'b0;
    repeat (3) @(posedge clock);
    query(SEV_OP_RD_STD_EV, 16'h0001, "std");
    // operation, questionable and message summaries at once, then clear-status
    issue(SEV_OP_PRESET, 16'h0000);
    issue(SEV_OP_WR_QUES_EN, 16'h0400);
    issue(SEV_OP_WR_OPER_EN, 16'h0400);
    @(posedge clock) msg_available <= 1'b1;
    set_cond(16'h0400, 16'h0400);
    check_stb(8'h98);
    issue(SEV_OP_CLS, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    check_stb(8'h10);
    query(SEV_OP_RD_STB, 16'h0010, "stb");
    // preset restores falling filter to zero
    issue(SEV_OP_WR_QUES_FALL, 16'h0400);
    issue(SEV_OP_PRESET, 16'h0000);
    set_cond(16'h0000, 16'h0000);
    query(SEV_OP_RD_QUES_EV, 16'h0000, "ques");
    pulse_src(4'h1);
    issue(SEV_OP_RST, 16'h0000);
    query(SEV_OP_RD_STD_EV, 16'h0000, "std");
    report_and_stop();
  end
endmodule : tb_top
